/* verilog/ddrl_map.svh */
// widths, depths and latency figures of the ddr link
`ifndef DDRL_MAP_SVH
`define DDRL_MAP_SVH
`define DDRL_USER_W 32
`define DDRL_EXT_W 8
`define DDRL_PAIR_W 16
`define DDRL_PAIRS 2
`define DDRL_PAIR_IW 1
`define DDRL_TX_DEPTH 16
`define DDRL_TX_AW 4
`define DDRL_RX_DEPTH 16
`define DDRL_RX_AW 4
`define DDRL_CDC_DEPTH 4
`define DDRL_CDC_PW 3
`define DDRL_LAT_R2 11
`define DDRL_LAT_R4 12
`define DDRL_LAT_R8 14
`define DDRL_LAT_R16 18
`define DDRL_LAT_R32 26
`endif

/* verilog/ddrl_pkg.sv */
// state types of the ddr link
`include "ddrl_map.svh"
package ddrl_pkg;
  typedef struct packed {
    logic [`DDRL_CDC_PW-1:0] bin;
    logic [`DDRL_CDC_PW-1:0] gray;
    logic [`DDRL_CDC_PW-1:0] s1;
    logic [`DDRL_CDC_PW-1:0] s2;
  } ddrl_ptr_t;

  typedef struct packed {
    logic [`DDRL_TX_AW:0] tx_wp;
    logic [`DDRL_TX_AW:0] tx_rp;
    logic [`DDRL_PAIR_IW-1:0] slice;
    logic [`DDRL_RX_AW:0] rx_wp;
    logic [`DDRL_RX_AW:0] rx_rp;
    logic [`DDRL_PAIR_W-1:0] acc;
    logic [`DDRL_PAIR_IW-1:0] acc_n;
    logic [`DDRL_USER_W-1:0] rd_data;
    logic tx_full;
    logic rx_empty;
    logic [1:0] lock_s1;
    logic [1:0] lock_s2;
  } ddrl_sys_t;

  typedef struct packed {
    logic rst_s1;
    logic rst_s2;
    logic phase;
    logic link_clock;
    logic valid;
    logic [`DDRL_EXT_W-1:0] data;
    logic [`DDRL_EXT_W-1:0] hi;
  } ddrl_txl_t;

  typedef struct packed {
    logic rst_s1;
    logic rst_s2;
    logic pair_valid;
    logic [`DDRL_PAIR_W-1:0] pair;
  } ddrl_rxl_t;
endpackage : ddrl_pkg

/* verilog/ddrl_link.sv */
// source-synchronous ddr link: transmitter and receiver ends
`timescale 1ns/100ps
`default_nettype none

// gray-coded four entry crossing fifo; pointers carry one wrap bit so
// full and empty differ, and only gray words cross between the clocks
module ddrl_cdc_fifo
  import ddrl_pkg::*;
#(
  parameter int W = 16
)
(
  input wire logic wr_clk, // write side clock
  input wire logic wr_rst, // write side reset
  input wire logic wr_en, // push
  input wire logic [W-1:0] wr_data, // pushed word
  output logic wr_full, // no room
  input wire logic rd_clk, // read side clock
  input wire logic rd_rst, // read side reset
  input wire logic rd_en, // pop
  output logic [W-1:0] rd_data, // head word
  output logic rd_empty // nothing held
);
  import ddrl_pkg::*;
  ddrl_ptr_t w_q, w_d, r_q, r_d;
  logic [W-1:0] mem_q [`DDRL_CDC_DEPTH];

  assign wr_full = (w_q.gray == {~w_q.s2[2:1], w_q.s2[0]});
  assign rd_empty = (r_q.gray == r_q.s2);
  // head word read without a register; its slot is stable until popped
  assign rd_data = mem_q[r_q.bin[1:0]];

  always_comb
  begin
    w_d = w_q;
    w_d.s1 = r_q.gray;
    w_d.s2 = w_q.s1;
    if (wr_en && !wr_full)
    begin
      w_d.bin = w_q.bin + 3'h1;
      w_d.gray = (w_d.bin >> 1) ^ w_d.bin;
    end
    if (wr_rst)
    begin
      w_d = '0;
    end
  end

  always_comb
  begin
    r_d = r_q;
    r_d.s1 = w_q.gray;
    r_d.s2 = r_q.s1;
    if (rd_en && !rd_empty)
    begin
      r_d.bin = r_q.bin + 3'h1;
      r_d.gray = (r_d.bin >> 1) ^ r_d.bin;
    end
    if (rd_rst)
    begin
      r_d = '0;
    end
  end

  always_ff @(posedge wr_clk)
  begin
    w_q <= w_d;
    if (wr_en && !wr_full)
    begin
      mem_q[w_q.bin[1:0]] <= wr_data;
    end
  end

  always_ff @(posedge rd_clk)
  begin
    r_q <= r_d;
  end
endmodule : ddrl_cdc_fifo

// two-way link: this end drives the tx_link pins, the far end the
// rx_link pins; both directions are handled in this one module
// pairs: word bits [15:0] leave first, each pair as low beat on the
// rising half and high beat on the falling half of the forwarded clock
// no back-pressure across the wire: a full realigner drops pairs

module ddrl_link
(
  input wire logic sys_clk, // user clock
  input wire logic reset, // sync reset, high
  input wire logic link_clk2x, // double rate transmit clock
  input wire logic tx_lock_in, // transmit clock generator lock
  input wire logic rx_lock_in, // receive clock generator lock
  input wire logic tx_wr_en, // user write strobe
  input wire logic [`DDRL_USER_W-1:0] tx_wr_data, // transmit_user_bus
  output logic tx_full, // transmit fifo full
  input wire logic rx_rd_en, // user read strobe
  output logic [`DDRL_USER_W-1:0] rx_rd_data, // receive_user_bus
  output logic rx_empty, // receive fifo empty
  output logic tx_locked, // transmit lock, synchronised
  output logic rx_locked, // receive lock, synchronised
  output logic tx_link_clock, // forwarded link_clock
  output logic [`DDRL_EXT_W-1:0] tx_link_data, // ddr data out
  output logic tx_link_valid, // beat valid out
  input wire logic rx_link_clock, // forwarded clock from peer
  input wire logic [`DDRL_EXT_W-1:0] rx_link_data, // ddr data in
  input wire logic rx_link_valid // beat valid in
);
  import ddrl_pkg::*;

  ddrl_sys_t s_q, s_d;
  ddrl_txl_t t_q, t_d;
  ddrl_rxl_t r_q, r_d;
  logic [`DDRL_USER_W-1:0] txmem_q [`DDRL_TX_DEPTH];
  logic [`DDRL_USER_W-1:0] rxmem_q [`DDRL_RX_DEPTH];
  logic [`DDRL_EXT_W-1:0] lo_q;
  logic [`DDRL_EXT_W-1:0] beat;
  logic tx_push;
  logic rx_push;
  logic rx_word_wr;
  logic tc_full, tc_empty, tc_pop;
  logic rc_full, rc_empty, rc_pop;
  logic [`DDRL_PAIR_W-1:0] tc_wdata, tc_rdata, rc_rdata;
  logic [`DDRL_USER_W-1:0] tx_word; // two pairs wide
  logic tc_rd_en;
  logic [`DDRL_PAIR_W-1:0] pair_in;
  logic [`DDRL_TX_AW:0] tx_fill;
  logic [`DDRL_RX_AW:0] rx_fill;

  assign tx_word = txmem_q[s_q.tx_rp[`DDRL_TX_AW-1:0]];
  assign tc_wdata = tx_word[s_q.slice*`DDRL_PAIR_W +: `DDRL_PAIR_W];

  // user clock domain: write port, funnel, widen, read port
  always_comb
  begin
    s_d = s_q;
    tx_push = 1'b0;
    rx_push = 1'b0;
    rx_word_wr = 1'b0;
    // lock pins are asynchronous: two flops before use
    s_d.lock_s1 = {tx_lock_in, rx_lock_in};
    s_d.lock_s2 = s_q.lock_s1;

    // write port
    if (tx_wr_en && !s_q.tx_full)
    begin
      tx_push = 1'b1;
      s_d.tx_wp = s_q.tx_wp + 5'h01;
    end

    // funnel: one pair a cycle into the crossing fifo
    if ((s_q.tx_wp != s_q.tx_rp) && !tc_full)
    begin
      s_d.slice = s_q.slice + 1'b1;
      if (s_q.slice == `DDRL_PAIR_IW'(`DDRL_PAIRS - 1))
      begin
        s_d.slice = '0;
        s_d.tx_rp = s_q.tx_rp + 5'h01;
      end
    end
    tx_fill = s_d.tx_wp - s_d.tx_rp;
    s_d.tx_full = (tx_fill == 5'(`DDRL_TX_DEPTH));

    // widen: first pair is held, second pair completes the word
    // and both are written together
    rx_fill = s_q.rx_wp - s_q.rx_rp;
    if (!rc_empty && (rx_fill != 5'(`DDRL_RX_DEPTH)))
    begin
      rx_push = 1'b1;
      s_d.acc = rc_rdata;
      s_d.acc_n = s_q.acc_n + 1'b1;
      if (s_q.acc_n == `DDRL_PAIR_IW'(`DDRL_PAIRS - 1))
      begin
        rx_word_wr = 1'b1;
        s_d.acc_n = '0;
        s_d.rx_wp = s_q.rx_wp + 5'h01;
      end
    end

    // read port
    if (rx_rd_en && !s_q.rx_empty)
    begin
      s_d.rd_data = rxmem_q[s_q.rx_rp[`DDRL_RX_AW-1:0]];
      s_d.rx_rp = s_q.rx_rp + 5'h01;
    end
    s_d.rx_empty = (s_d.rx_wp == s_d.rx_rp);
    if (reset)
    begin
      s_d = '0;
      s_d.rx_empty = 1'b1;
    end
  end
  assign tc_pop = 1'b0 | ((s_q.tx_wp != s_q.tx_rp) & ~tc_full);
  assign rc_pop = rx_push;

  // user clock shared in phase with the far end
  always_ff @(posedge sys_clk)
  begin
    s_q <= s_d;
    if (tx_push)
    begin
      txmem_q[s_q.tx_wp[`DDRL_TX_AW-1:0]] <= tx_wr_data;
    end
    if (rx_word_wr)
    begin
      rxmem_q[s_q.rx_wp[`DDRL_RX_AW-1:0]] <= {rc_rdata, s_q.acc};
    end
  end

  assign tx_full = s_q.tx_full;
  assign rx_empty = s_q.rx_empty;
  assign rx_rd_data = s_q.rd_data;
  assign tx_locked = s_q.lock_s2[1];
  assign rx_locked = s_q.lock_s2[0];

  // pop only on the edge that sends a low beat
  assign tc_rd_en = ~t_q.phase;

  // sys_clk writes pairs, link_clk2x reads them
  ddrl_cdc_fifo #(.W(`DDRL_PAIR_W)) u_tx_cdc (
    .wr_clk(sys_clk),
    .wr_rst(reset),
    .wr_en(tc_pop),
    .wr_data(tc_wdata),
    .wr_full(tc_full),
    .rd_clk(link_clk2x),
    .rd_rst(t_q.rst_s2),
    .rd_en(tc_rd_en),
    .rd_data(tc_rdata),
    .rd_empty(tc_empty)
  );

  // single to ddr converter, one per external bit
  // low beat straight from the fifo head, high beat from the held copy
  genvar g;
  generate
    for (g = 0; g < `DDRL_EXT_W; g++)
    begin : g_s2d
      assign beat[g] = t_q.phase ? t_q.hi[g] : tc_rdata[g];
    end
  endgenerate

  // double rate domain: beat on every edge, clock forwarded at half rate
  // phase 0 pops a pair and sends its low beat, phase 1 the high beat
  always_comb
  begin
    t_d = t_q;
    t_d.rst_s1 = reset;
    t_d.rst_s2 = t_q.rst_s1;
    t_d.phase = ~t_q.phase;
    t_d.link_clock = ~t_q.phase;
    if (t_q.phase == 1'b0)
    begin
      t_d.valid = ~tc_empty;
      t_d.hi = tc_rdata[`DDRL_PAIR_W-1 -: `DDRL_EXT_W];
      t_d.data = tc_empty ? '0 : beat;
    end
    else
    begin
      t_d.data = t_q.valid ? beat : '0;
    end
    if (t_q.rst_s2)
    begin
      t_d.valid = 1'b0;
      t_d.data = '0;
      t_d.hi = '0;
      // clock keeps running in reset so the far end sees reset too;
      // the first reset edge parks it low from an unknown start
      if (!t_q.valid)
      begin
        t_d.link_clock = ~t_q.link_clock;
      end
      else
      begin
        t_d.link_clock = 1'b0;
      end
      // phase tracks the clock, so the first pair after reset is aligned
      t_d.phase = t_d.link_clock;
    end
  end

  always_ff @(posedge link_clk2x)
  begin
    t_q <= t_d;
  end

  assign tx_link_clock = t_q.link_clock;
  assign tx_link_data = t_q.data; // outbound only
  assign tx_link_valid = t_q.valid;

  // ddr to single converter: low beat on falling edge, per bit
  generate
    for (g = 0; g < `DDRL_EXT_W; g++)
    begin : g_d2s
      always_ff @(negedge rx_link_clock)
      begin
        lo_q[g] <= rx_link_data[g];
      end
      assign pair_in[g] = lo_q[g];
      assign pair_in[g + `DDRL_EXT_W] = rx_link_data[g];
    end
  endgenerate

  // forwarded clock domain: pair the beats and push to the realigner
  always_comb
  begin
    r_d = r_q;
    r_d.rst_s1 = reset;
    r_d.rst_s2 = r_q.rst_s1;
    r_d.pair_valid = rx_link_valid;
    // valid leaves with the low beat and holds through the high beat, so the pair is whole here
    r_d.pair = pair_in;
    if (r_q.rst_s2)
    begin
      r_d.pair_valid = 1'b0;
      r_d.pair = '0;
    end
  end

  always_ff @(posedge rx_link_clock)
  begin
    r_q <= r_d;
  end

  // four entry realigner into the user clock
  // wire delay only moves where pairs land in it, never the rate;
  // at ratio 4 a word reaches the read port within 12 link periods,
  // and each extra period of wire delay adds one capture period
  ddrl_cdc_fifo #(.W(`DDRL_PAIR_W)) u_rx_cdc (
    .wr_clk(rx_link_clock),
    .wr_rst(r_q.rst_s2),
    .wr_en(r_q.pair_valid),
    .wr_data(r_q.pair),
    .wr_full(rc_full),
    .rd_clk(sys_clk),
    .rd_rst(reset),
    .rd_en(rc_pop),
    .rd_data(rc_rdata),
    .rd_empty(rc_empty)
  );
endmodule : ddrl_link

`default_nettype wire

/* testbench/ddrl_peer.sv */
// peer model: carries the forwarded link back over a delayed wire
`timescale 1ns/100ps
`default_nettype none
`include "ddrl_map.svh"
module ddrl_peer
(
  input wire logic clk_in, // forwarded clock
  input wire logic [`DDRL_EXT_W-1:0] data_in, // ddr beats
  input wire logic valid_in, // pair marker
  output logic clk_out, // clock to receiver
  output logic [`DDRL_EXT_W-1:0] data_out, // beats to receiver
  output logic valid_out // marker to receiver
);
  int pairs = 0;
  assign #3 clk_out = clk_in;
  // data lags the clock by a quarter beat: edges land a quarter beat before each beat ends
  assign #6 data_out = data_in;
  assign #6 valid_out = valid_in;
  // low beat rises the clock, so one count per pair
  always @(posedge clk_out)
    if (valid_in) pairs++;
endmodule : ddrl_peer
`default_nettype wire

/* testbench/ddrl_link_assertions.sv */
// port assertions of the ddr link
`timescale 1ns/100ps
`default_nettype none
`include "ddrl_map.svh"
module ddrl_link_chk
(
  input wire logic sys_clk, // user clock
  input wire logic reset, // reset
  input wire logic link_clk2x, // fast clock
  input wire logic tx_lock_in, // lock in
  input wire logic rx_lock_in, // lock in
  input wire logic tx_wr_en, // write
  input wire logic tx_full, // full
  input wire logic rx_rd_en, // read
  input wire logic [`DDRL_USER_W-1:0] rx_rd_data, // read word
  input wire logic rx_empty, // empty
  input wire logic tx_locked, // lock out
  input wire logic rx_locked, // lock out
  input wire logic tx_link_clock, // link clock
  input wire logic [`DDRL_EXT_W-1:0] tx_link_data, // beats
  input wire logic tx_link_valid // marker
);
  logic [2:0] run_q;
  // link domain settles a few edges after reset
  always_ff @(posedge link_clk2x)
    if (reset) run_q <= 3'h0;
    else if (run_q != 3'h7) run_q <= run_q + 3'h1;
  sequence s_lo;
    tx_link_valid && tx_link_clock;
  endsequence
  sequence s_hi;
    tx_link_valid && !tx_link_clock;
  endsequence
  AST_RESET_VAL: assert property (@(posedge sys_clk) reset |=>
    !tx_full && rx_empty && rx_rd_data == '0 && !tx_locked)
    else $error("reset values wrong");
  AST_FULL_CAUSE: assert property (@(posedge sys_clk)
    disable iff (reset) $rose(tx_full) |-> $past(tx_wr_en))
    else $error("full without write");
  AST_RD_HOLD: assert property (@(posedge sys_clk)
    disable iff (reset) !rx_rd_en |=> $stable(rx_rd_data))
    else $error("read data moved");
  AST_RD_EMPTY: assert property (@(posedge sys_clk)
    disable iff (reset) rx_rd_en && rx_empty |=> $stable(rx_rd_data))
    else $error("empty read");
  AST_TX_LOCK: assert property (@(posedge sys_clk)
    disable iff (reset) !$past(reset) && !$past(reset, 2) |->
    tx_locked == $past(tx_lock_in, 2)) else $error("tx lock wrong");
  AST_RX_LOCK: assert property (@(posedge sys_clk)
    disable iff (reset) !$past(reset) && !$past(reset, 2) |->
    rx_locked == $past(rx_lock_in, 2)) else $error("rx lock wrong");
  AST_CLK_TOGGLE: assert property (@(posedge link_clk2x)
    disable iff (reset) run_q == 3'h7 |-> tx_link_clock != $past(tx_link_clock))
    else $error("link clock stuck");
  AST_DDR_PAIR: assert property (@(posedge link_clk2x)
    disable iff (reset) run_q == 3'h7 ##0 s_lo |=> s_hi)
    else $error("pair broken");
  AST_IDLE_ZERO: assert property (@(posedge link_clk2x)
    disable iff (reset) run_q == 3'h7 && !tx_link_valid |-> tx_link_data == '0)
    else $error("idle data");
endmodule : ddrl_link_chk
bind ddrl_link ddrl_link_chk u_chk (.sys_clk, .reset, .link_clk2x,
  .tx_lock_in, .rx_lock_in, .tx_wr_en, .tx_full, .rx_rd_en, .rx_rd_data,
  .rx_empty, .tx_locked, .rx_locked, .tx_link_clock, .tx_link_data,
  .tx_link_valid);
`default_nettype wire

/* testbench/ddrl_link_tb.sv */
// self-checking bench of the ddr link in loopback
`timescale 1ns/100ps
`default_nettype none
`include "ddrl_map.svh"
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin \
  num_errors++; $display("[FAIL] %s expected %0h seen %0h", n, e, g); end end
module ddrl_link_tb;
  logic sys_clk, reset, link_clk2x, tx_lock_in, rx_lock_in;
  logic tx_wr_en, rx_rd_en, tx_full, rx_empty, tx_locked, rx_locked;
  logic [`DDRL_USER_W-1:0] tx_wr_data, rx_rd_data, e, g;
  logic lclk, lvalid, pclk, pvalid, taken_q, saw_full;
  logic [`DDRL_EXT_W-1:0] ldata, pdata;
  logic [`DDRL_USER_W-1:0] exp_q[$], got[$];
  int num_errors = 0, total_checks = 0;
  ddrl_link dut (.sys_clk, .reset, .link_clk2x, .tx_lock_in, .rx_lock_in,
    .tx_wr_en, .tx_wr_data, .tx_full, .rx_rd_en, .rx_rd_data, .rx_empty,
    .tx_locked, .rx_locked, .tx_link_clock(lclk), .tx_link_data(ldata),
    .tx_link_valid(lvalid), .rx_link_clock(pclk), .rx_link_data(pdata),
    .rx_link_valid(pvalid));
  ddrl_peer peer (.clk_in(lclk), .data_in(ldata), .valid_in(lvalid),
    .clk_out(pclk), .data_out(pdata), .valid_out(pvalid));
  initial
  begin
    sys_clk = 0;
    forever #2 sys_clk = ~sys_clk;
  end
  initial
  begin
    link_clk2x = 0;
    #1.3;
    forever #6 link_clk2x = ~link_clk2x;
  end
  // reader pops every other cycle while data is offered
  always @(posedge sys_clk)
  begin
    if (taken_q) got.push_back(rx_rd_data);
    taken_q <= rx_rd_en && !rx_empty && !reset;
    rx_rd_en <= !reset && !rx_empty && !rx_rd_en;
  end
  task automatic print_verdict();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : print_verdict
  task automatic send(input int n, input logic [31:0] base);
    int i;
    i = 0;
    for (int t = 0; t < 200 * n + 2 && i < n; t++)
    begin
      @(posedge sys_clk);
      if (tx_wr_en && !tx_full)
      begin
        exp_q.push_back(tx_wr_data);
        i++;
      end
      if (tx_full) saw_full = 1;
      // every other cycle, so full is seen before the next write
      tx_wr_en <= (i < n) && !tx_wr_en && !tx_full;
      tx_wr_data <= base + i;
    end
    if (i < n)
    begin
      $display("[FAIL] send expected %0d seen %0d", n, i);
      num_errors++;
      print_verdict();
    end
  endtask : send
  task automatic drain(input int lim);
    int t;
    for (t = 0; t < lim && got.size() < exp_q.size(); t++) @(posedge sys_clk);
    if (got.size() < exp_q.size())
    begin
      $display("[FAIL] arrival expected %0d seen %0d", exp_q.size(), got.size());
      num_errors++;
      print_verdict();
    end
    while (exp_q.size() > 0)
    begin
      e = exp_q.pop_front();
      g = got.pop_front();
      `CHK("rx_rd_data", e, g)
    end
  endtask : drain
  task automatic test_lock();
    for (int i = 0; i < 2; i++)
    begin
      tx_lock_in <= i[0];
      rx_lock_in <= !i[0];
      repeat (3) @(posedge sys_clk);
      `CHK("tx_locked", i[0], tx_locked)
      `CHK("rx_locked", !i[0], rx_locked)
    end
    $display("test lock done");
  endtask : test_lock
  task automatic test_latency();
    send(1, 32'h5aa5c33c);
    drain(`DDRL_LAT_R4 * 6);
    $display("test latency done");
  endtask : test_latency
  task automatic test_burst();
    int p0;
    p0 = peer.pairs;
    send(8, 32'h80ff0100);
    drain(3000);
    `CHK("pairs", 16, peer.pairs - p0)
    $display("test burst done");
  endtask : test_burst
  task automatic test_fill();
    saw_full = 0;
    send(24, 32'hf00d0000);
    `CHK("saw_full", 1'b1, saw_full)
    drain(4000);
    repeat (4) @(posedge sys_clk);
    `CHK("rx_empty", 1'b1, rx_empty)
    `CHK("extra", 0, got.size())
    $display("test fill done");
  endtask : test_fill
  initial
  begin
    reset = 1;
    tx_lock_in = 0;
    rx_lock_in = 0;
    tx_wr_en = 0;
    tx_wr_data = '0;
    rx_rd_en = 0;
    taken_q = 0;
    repeat (16) @(posedge sys_clk);
    reset <= 0;
    repeat (8) @(posedge sys_clk);
    test_lock();
    test_latency();
    test_burst();
    test_fill();
    print_verdict();
  end
endmodule : ddrl_link_tb
`default_nettype wire
